// *** rtl/disk_ctrl_bus_master_port.sv ***
`timescale 1ns/100ps
`include "dma_port_regs.svh"
// Operation
// - Assert the dma request line when a FIFO word must move to or from memory and mastership is not already held.
// - On grant, drop the request and assert the bus-master acknowledge.
// - Mastership is used only for FIFO-to-memory and memory-to-FIFO word moves.
// - The two extended address lines are never driven and their inputs ignored.
// - Write data is valid on the shared lines for the whole write strobe period.
// - The write strobe is delayed until the data lines have settled.
// - A write ends only on the slave reply; strobe and data hold until then.
// - Primary power-good is buffered onto the drive-bus power-fail output.
// - While primary power-good is low, no dma transfer is started.
// - Sync asserts after the address is placed and the cycle lasts until sync drops.
// - The write/byte flag is asserted at the leading edge of sync for a write.
// - The read strobe asserts inside sync when ready, then waits for the reply.
module disk_ctrl_bus_master_port
   import dma_port_pkg::*;
(
   // clock, reset, enable
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic                 clk_en,
   // fifo side (controller)
   input  wire logic                 xfer_start,
   input  wire logic                 xfer_write,
   input  wire logic [`ADDR_W-1:0]   xfer_addr,
   input  wire logic [`DATA_W-1:0]   xfer_wdata,
   input  wire logic                 xfer_last,
   output logic                      xfer_done,
   output logic [`DATA_W-1:0]        xfer_rdata,
   output logic                      xfer_busy,
   // arbitration
   output logic                      dma_bus_request,
   input  wire logic                 dma_grant_out,
   output logic                      bus_master_ack,
   // bus cycle control
   output logic                      cycle_sync,
   output logic                      write_byte_flag,
   output logic                      write_data_strobe,
   output logic                      read_data_strobe,
   input  wire logic                 slave_reply,
   // multiplexed data/address lines
   input  wire logic [`DATA_W-1:0]   muxed_data_addr_in,
   output logic [`DATA_W-1:0]        muxed_data_addr_out,
   output logic                      muxed_data_addr_oe,
   // extended address lines, never driven
   output logic [1:0]                ext_addr_oe,
   // power status
   input  wire logic                 primary_power_good,
   input  wire logic                 dc_power_good,
   output logic                      drive_power_fail
);
   import dma_port_pkg::*;

   typedef struct packed {
      port_state_t         state;
      logic [`CNT_W-1:0]   cnt;
      logic                write;
      logic                last;
      logic [`ADDR_W-1:0]  addr;
      logic [`DATA_W-1:0]  wdata;
      logic [`DATA_W-1:0]  rdata;
      logic                done;
      logic                pfail;
   } port_regs_t;

   port_regs_t cur_reg;
   port_regs_t cur_next;

   // words may only start while both power-good levels are up
   logic power_ok;
   assign power_ok = primary_power_good & dc_power_good;

   // next-state logic of the whole port
   always_comb
   begin
      cur_next = cur_reg;
      cur_next.done = 1'b0;
      cur_next.pfail = ~primary_power_good;
      case (cur_reg.state)
         st_idle:
         begin
            // a new word is only accepted with good power
            if (xfer_start && power_ok)
            begin
               cur_next.write = xfer_write;
               cur_next.addr  = xfer_addr;
               cur_next.wdata = xfer_wdata;
               cur_next.last  = xfer_last;
               cur_next.state = st_request;
            end
         end
         st_request:
         begin
            // grant arrives only when the arbiter is off the bus
            if (dma_grant_out)
            begin
               cur_next.cnt   = `ZERO_CNT;
               cur_next.state = st_addr;
            end
         end
         st_addr:
         begin
            // address settles one cycle before sync
            cur_next.cnt = cur_reg.cnt + `ONE_CNT;
            if (cur_reg.cnt + `ONE_CNT >= `CNT_W'(`ADDR_SETUP_CYC))
            begin
               cur_next.cnt   = `ZERO_CNT;
               cur_next.state = st_sync;
            end
         end
         st_sync:
         begin
            // data replaces address, then strobe after deskew
            cur_next.cnt = cur_reg.cnt + `ONE_CNT;
            if (!cur_reg.write)
               cur_next.state = st_wait_reply;
            else if (cur_reg.cnt + `ONE_CNT >= `CNT_W'(`DESKEW_CYC))
               cur_next.state = st_wait_reply;
         end
         st_wait_reply:
         begin
            // strobe and data hold until the slave replies
            if (slave_reply)
            begin
               cur_next.rdata = cur_reg.write ? cur_reg.rdata
                                              : muxed_data_addr_in;
               cur_next.state = st_end_cycle;
            end
         end
         st_end_cycle:
         begin
            // wait for reply to drop before ending the cycle
            if (!slave_reply)
            begin
               cur_next.done = 1'b1;
               if (cur_reg.last || !power_ok)
                  cur_next.state = st_idle;
               else
                  cur_next.state = st_strobe;
            end
         end
         st_strobe:
         begin
            // hold mastership while the fifo offers the next word
            if (!power_ok)
               cur_next.state = st_idle;
            else if (xfer_start)
            begin
               cur_next.write = xfer_write;
               cur_next.addr  = xfer_addr;
               cur_next.wdata = xfer_wdata;
               cur_next.last  = xfer_last;
               cur_next.cnt   = `ZERO_CNT;
               cur_next.state = st_addr;
            end
         end
         default:
            cur_next.state = st_idle;
      endcase
   end

   // one register holds the whole port state; enable freezes it
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         cur_reg <= '0;
      else if (clk_en)
         cur_reg <= cur_next;
   end

   // bus outputs decoded from state
   logic in_cycle;
   logic master;
   assign in_cycle = (cur_reg.state == st_sync) ||
                     (cur_reg.state == st_wait_reply);
   assign master   = (cur_reg.state == st_addr) || in_cycle ||
                     (cur_reg.state == st_end_cycle) ||
                     (cur_reg.state == st_strobe);

   assign dma_bus_request   = (cur_reg.state == st_request);
   assign bus_master_ack    = master;
   assign cycle_sync        = in_cycle;
   // flag set on the sync edge, held through the write
   assign write_byte_flag   = in_cycle && cur_reg.write;
   assign write_data_strobe = (cur_reg.state == st_wait_reply) &&
                              cur_reg.write;
   assign read_data_strobe  = (cur_reg.state == st_wait_reply) &&
                              !cur_reg.write;
   // address during addr phase, write data during the sync phase
   assign muxed_data_addr_out = (cur_reg.state == st_addr) ? cur_reg.addr
                                                         : cur_reg.wdata;
   assign muxed_data_addr_oe  = (cur_reg.state == st_addr) ||
                                (in_cycle && cur_reg.write);
   assign ext_addr_oe       = 2'h0;
   assign drive_power_fail  = cur_reg.pfail;
   assign xfer_done         = cur_reg.done;
   assign xfer_rdata        = cur_reg.rdata;
   assign xfer_busy         = (cur_reg.state != st_idle);

   // request drops once grant moves us on
   grant_drops_req_a: assert property (@(posedge core_clk) disable iff (rst)
      (clk_en && cur_reg.state == st_request && dma_grant_out) |=>
      (!dma_bus_request && bus_master_ack))
      else $error("request not dropped on grant");

   // no new word is started with power low
   power_inhibit_a: assert property (@(posedge core_clk) disable iff (rst)
      (cur_reg.state == st_idle && !primary_power_good) |=>
      !dma_bus_request)
      else $error("dma started with power low");

   // write data and strobe hold until reply
   strobe_hold_a: assert property (@(posedge core_clk) disable iff (rst)
      (write_data_strobe && !slave_reply) |=>
      (write_data_strobe && $stable(muxed_data_addr_out) &&
       muxed_data_addr_oe))
      else $error("write strobe dropped before reply");

   // strobe never rises in the first sync cycle
   deskew_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(write_data_strobe) |-> $past(cycle_sync, 2))
      else $error("write strobe not deskewed");

   // sync is preceded by the address on the lines
   addr_before_sync_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(cycle_sync) |-> $past(muxed_data_addr_oe))
      else $error("sync without address");

   // flag follows direction from the sync edge
   write_flag_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(cycle_sync) |-> (write_byte_flag == cur_reg.write))
      else $error("write flag wrong at sync");

   // flag is decided at the sync edge and may not move inside the cycle
   wtbt_steady_a: assert property (@(posedge core_clk) disable iff (rst)
      (cycle_sync && $past(cycle_sync)) |-> $stable(write_byte_flag))
      else $error("write flag changed inside sync");

   // read strobe only inside sync and with ack
   read_in_sync_a: assert property (@(posedge core_clk) disable iff (rst)
      read_data_strobe |-> (cycle_sync && bus_master_ack &&
                            !muxed_data_addr_oe))
      else $error("read strobe outside sync");

   // power fail output tracks power-good one cycle later
   power_relay_a: assert property (@(posedge core_clk) disable iff (rst)
      clk_en |=> (drive_power_fail == !$past(primary_power_good)))
      else $error("power fail relay wrong");

   // extended lines stay undriven
   ext_undriven_a: assert property (@(posedge core_clk) disable iff (rst)
      ext_addr_oe == 2'h0)
      else $error("extended lines driven");

   // request and ack never together
   req_ack_excl_a: assert property (@(posedge core_clk) disable iff (rst)
      !(dma_bus_request && bus_master_ack))
      else $error("request and ack together");

endmodule : disk_ctrl_bus_master_port

// *** include/dma_port_regs.svh ***
`ifndef DMA_PORT_REGS_SVH
`define DMA_PORT_REGS_SVH

// bus word width and address width of the multiplexed lines
`define DATA_W       16
`define ADDR_W       16
// ns the data is held before write strobe asserts (deskew), rounded up to whole clock cycles
`define DESKEW_NS    100
`define CLK_NS       50
`define DESKEW_CYC   ((`DESKEW_NS + `CLK_NS - 1) / `CLK_NS)
// cycles the address is held before cycle sync asserts
`define ADDR_SETUP_CYC 1
`define CNT_W        4
`define ONE_CNT      4'h1
`define ZERO_CNT     4'h0

`endif

// *** include/dma_port_pkg.sv ***
package dma_port_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_request,
      st_addr,
      st_sync,
      st_strobe,
      st_wait_reply,
      st_end_cycle
   } port_state_t;
endpackage : dma_port_pkg

// *** tb/host_bus_partner.sv ***
`timescale 1ns/100ps
module host_bus_partner
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // answer delay in cycles
   input  wire logic [3:0]  dly,
   // from the port
   input  wire logic        req,
   input  wire logic        sync,
   input  wire logic        wtbt,
   input  wire logic        wstb,
   input  wire logic        rstb,
   input  wire logic [15:0] bus,
   // answers
   output logic             gnt,
   output logic             reply,
   output logic [15:0]      rdata,
   output logic             rd_oe
);
   logic [15:0] mem [0:15];
   logic [15:0] addr_reg;
   logic [3:0]  cnt;
   logic        sync_d;
   logic        wr_reg;
   logic [15:0] bus_d;
   // read data only driven while the read strobe is up
   assign rdata = mem[addr_reg[3:0]];
   assign rd_oe = rstb && !wr_reg;
   // one counter times both grant and reply, so slow means slow for both
   always @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         gnt    <= 1'b0;
         reply  <= 1'b0;
         cnt    <= 4'h0;
         sync_d <= 1'b0;
         wr_reg <= 1'b0;
      end
      else
      begin
         sync_d <= sync;
         bus_d  <= bus;
         cnt    <= (req || wstb || rstb) && cnt != 4'hf ? cnt + 4'h1 : 4'h0;
         // the address stood on the lines just before sync rose;
         // the port swaps in write data as sync asserts
         if (sync && !sync_d)
         begin
            addr_reg <= bus_d;
            wr_reg   <= wtbt;
         end
         gnt <= req && cnt >= dly;
         if (wstb && wr_reg && cnt >= dly && !reply)
            mem[addr_reg[3:0]] <= bus;
         reply <= (wstb && wr_reg || rstb) && cnt >= dly;
      end
   end
endmodule : host_bus_partner

// *** tb/test_disk_ctrl_bus_master_port.sv ***
`timescale 1ns/100ps
`include "dma_port_regs.svh"
module test_disk_ctrl_bus_master_port;
   logic        core_clk, rst, clk_en, xfer_start, xfer_write, xfer_last;
   logic        xfer_done, xfer_busy, req, gnt, ack, sync, wtbt, wstb;
   logic        rstb, reply, oe, poe, ppg, dpg, pfail;
   logic [1:0]  ext_oe;
   logic [3:0]  dly;
   logic [15:0] xfer_addr, xfer_wdata, xfer_rdata, dout, pdata, hold;
   wire  [15:0] bus;
   int          n_errors, tests_run;
   // released lines flip every cycle so a stale value cannot pass
   assign bus = oe ? dout : (poe ? pdata : hold);
   always @(posedge core_clk)
      hold <= ~bus;
   disk_ctrl_bus_master_port dut (.core_clk(core_clk), .rst(rst),
      .clk_en(clk_en), .xfer_start(xfer_start), .xfer_write(xfer_write),
      .xfer_addr(xfer_addr), .xfer_wdata(xfer_wdata), .xfer_last(xfer_last),
      .xfer_done(xfer_done), .xfer_rdata(xfer_rdata), .xfer_busy(xfer_busy),
      .dma_bus_request(req), .dma_grant_out(gnt), .bus_master_ack(ack),
      .cycle_sync(sync), .write_byte_flag(wtbt), .write_data_strobe(wstb),
      .read_data_strobe(rstb), .slave_reply(reply),
      .muxed_data_addr_in(bus), .muxed_data_addr_out(dout),
      .muxed_data_addr_oe(oe), .ext_addr_oe(ext_oe),
      .primary_power_good(ppg), .dc_power_good(dpg),
      .drive_power_fail(pfail));
   host_bus_partner p (.core_clk(core_clk), .rst(rst), .dly(dly),
      .req(req), .sync(sync), .wtbt(wtbt), .wstb(wstb), .rstb(rstb),
      .bus(bus), .gnt(gnt), .reply(reply), .rdata(pdata), .rd_oe(poe));
   // 50 ns clock
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask : tick
   task automatic check(input string what, input logic [15:0] seen, exp);
      tests_run++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   // one word; watches sync, strobe and reply until done
   task automatic do_word(input logic w, input logic [15:0] a, d,
                          input logic last);
      int   n;
      logic s_seen, stb_d, rep_d;
      n = 0;
      s_seen = 1'b0;
      stb_d = 1'b0;
      rep_d = 1'b0;
      xfer_write = w;
      xfer_addr = a;
      xfer_wdata = d;
      xfer_last = last;
      xfer_start = 1'b1;
      tick();
      xfer_start = 1'b0;
      if (ack !== 1'b1)
         check("request", {15'h0, req}, 16'h1);
      while (xfer_done !== 1'b1)
      begin
         if (ack === 1'b1)
            check("req_drop", {15'h0, req}, 16'h0);
         if (sync === 1'b1 && !s_seen)
         begin
            check("deskew", {15'h0, wstb}, 16'h0);
            check("wtbt", {15'h0, wtbt}, {15'h0, w});
            s_seen = 1'b1;
         end
         if (wstb === 1'b1)
            check("wdata", bus, d);
         if (stb_d && !(wstb || rstb))
            check("held", {15'h0, rep_d}, 16'h1);
         stb_d = wstb || rstb;
         rep_d = reply;
         n++;
         if (n == 100)
         begin
            n_errors++;
            print_verdict();
         end
         tick();
      end
      check("ext_oe", {14'h0, ext_oe}, 16'h0);
   endtask : do_word
   task automatic t_power();
      ppg = 1'b0;
      xfer_start = 1'b1;
      xfer_write = 1'b1;
      repeat (4) tick();
      check("power_fail", {15'h0, pfail}, 16'h1);
      check("no_dma", {15'h0, xfer_busy | req}, 16'h0);
      xfer_start = 1'b0;
      ppg = 1'b1;
      repeat (2) tick();
      check("power_ok", {15'h0, pfail}, 16'h0);
      $display("test power done");
   endtask : t_power
   // dc power low and a frozen enable both keep the port idle
   task automatic t_gates();
      dpg = 1'b0;
      xfer_start = 1'b1;
      repeat (3) tick();
      check("dc_low", {15'h0, xfer_busy | req}, 16'h0);
      dpg = 1'b1;
      clk_en = 1'b0;
      ppg = 1'b0;
      repeat (2) tick();
      check("frozen_pf", {15'h0, pfail}, 16'h0);
      ppg = 1'b1;
      repeat (2) tick();
      check("frozen_req", {15'h0, xfer_busy | req}, 16'h0);
      xfer_start = 1'b0;
      clk_en = 1'b1;
      tick();
      check("thawed", {15'h0, xfer_busy | pfail}, 16'h0);
      $display("test gates done");
   endtask : t_gates
   task automatic t_write();
      do_word(1'b1, 16'h0003, 16'ha5c3, 1'b0);
      check("ack_held", {15'h0, ack}, 16'h1);
      do_word(1'b1, 16'h0004, 16'h5a3c, 1'b1);
      repeat (3) tick();
      check("ack_rel", {15'h0, ack | req}, 16'h0);
      check("mem3", p.mem[3], 16'ha5c3);
      check("mem4", p.mem[4], 16'h5a3c);
      $display("test write done");
   endtask : t_write
   // slow grant and slow reply on a read
   task automatic t_read();
      dly = 4'h5;
      p.mem[7] = 16'h1e2d;
      do_word(1'b0, 16'h0007, 16'h0000, 1'b1);
      check("rdata", xfer_rdata, 16'h1e2d);
      dly = 4'h0;
      $display("test read done");
   endtask : t_read
   // power dropping between words ends the burst and returns the bus
   task automatic t_pfail();
      do_word(1'b1, 16'h0005, 16'h3c5a, 1'b0);
      ppg = 1'b0;
      tick();
      check("pf_ack", {15'h0, ack | req}, 16'h0);
      ppg = 1'b1;
      tick();
      check("mem5", p.mem[5], 16'h3c5a);
      $display("test power burst done");
   endtask : t_pfail
   initial
   begin
      n_errors = 0;
      tests_run = 0;
      hold = 16'h0000;
      rst = 1'b1;
      clk_en = 1'b1;
      xfer_start = 1'b0;
      xfer_write = 1'b0;
      xfer_last = 1'b0;
      xfer_addr = 16'h0000;
      xfer_wdata = 16'h0000;
      ppg = 1'b1;
      dpg = 1'b1;
      dly = 4'h0;
      repeat (5) @(posedge core_clk);
      #1;
      rst = 1'b0;
      t_power();
      t_gates();
      t_write();
      t_read();
      t_pfail();
      print_verdict();
   end
endmodule : test_disk_ctrl_bus_master_port
